// >>> shared/sri_pkg.sv
package sri_pkg;

  // sequencing lengths in oscillator cycles
  localparam int SRI_LONG_CYC  = 4096;
  localparam int SRI_SHORT_CYC = 64;
  localparam int SRI_SREC_CYC  = 32;

  localparam logic [11:0] SRI_CNT_RST   = 12'h000;
  localparam logic [11:0] SRI_CNT_MAX   = 12'hFFF;
  localparam logic [11:0] SRI_LONG_LAST = 12'(SRI_LONG_CYC - 1);
  localparam logic [11:0] SRI_SREC_LAST = 12'(SRI_SREC_CYC - 1);
  localparam logic [5:0]  SRI_SHORT_LAST = 6'(SRI_SHORT_CYC - 1);

  // register offsets
  localparam logic [7:0] SRI_OFS_BRK_STAT = 8'h00;
  localparam logic [7:0] SRI_OFS_RST_SRC  = 8'h01;
  localparam logic [7:0] SRI_OFS_BRK_CTL  = 8'h03;
  localparam logic [7:0] SRI_OFS_CFG      = 8'h04;

  // reset_source_status_reg fields
  localparam int SRI_RS_POR    = 7;
  localparam int SRI_RS_PIN    = 6;
  localparam int SRI_RS_WDOG   = 5;
  localparam int SRI_RS_ILOP   = 4;
  localparam int SRI_RS_ILAD   = 3;
  localparam int SRI_RS_MONENT = 2;
  localparam int SRI_RS_LOWV   = 1;

  // break status, break_flag_control_reg and config fields
  localparam int SRI_BS_WAIT_EXIT = 1;
  localparam int SRI_BC_CLR_EN    = 7;
  localparam int SRI_CFG_LVPD     = 0;
  localparam int SRI_CFG_LVRD     = 1;
  localparam int SRI_CFG_SREC     = 2;
  localparam int SRI_CFG_WDD      = 3;

  localparam logic [7:0] SRI_RST_SRC_POR = 8'h80;
  localparam logic [7:0] SRI_REG_ZERO    = 8'h00;
  localparam logic [7:0] SRI_ERASED_BYTE = 8'hFF;
  localparam logic [6:0] SRI_VEC_SOFT    = 7'h00;

  typedef enum logic [2:0] {
    SQ_LV_HOLD,
    SQ_LONG,
    SQ_SHORT,
    SQ_RUN,
    SQ_WAIT,
    SQ_STOP,
    SQ_STOP_REC
  } sri_state_e;

  typedef struct packed {
    logic       take;
    logic [6:0] vec;
    logic       pc_minus_one;
    logic       push_high_index;
  } sri_stack_s;

  typedef struct packed {
    logic wdd;
    logic short_rec;
    logic lvrd;
    logic lvpd;
  } sri_cfg_s;

endpackage

// >>> hw/sri_sequencer.sv
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// R1: erased reset vector bytes raise internal reset; release enters monitor mode.
// R2: low voltage sets its status bit and resets only if both cfg bits zero.
// R3: low-voltage reset holds until supply recovers, then 4096 plus 64 cycles.
// R4: system counter is 12 bits, advancing every oscillator cycle.
// R5: system counter overflow clocks the watchdog counter.
// R6: stop instruction clears the system counter.
// R7: stop exit samples short recovery bit: 32 cycles if set, else 4096.
// R8: after all reset states the counter runs freely.
// R9: interrupt entry stacks registers and sets the mask; return restores them.
// R10: interrupts latch with a vector constant; no override until serviced or unmasked.
// R11: hardware interrupts taken at instruction end if unmasked and enabled.
// R12: several pending interrupts: highest priority is serviced first.
// R13: interrupt pending at return is serviced before the next instruction; the code takes it at the return only if i_mask is already clear in that cycle.
// R14: high index register is never pushed on interrupt entry.
// R15: software interrupt is taken whatever the mask bit.
// R16: software interrupt stacks pc; hardware interrupt stacks pc minus one.
// R17: resets beat all interrupts and never join arbitration.
// R18: break output forces the cpu to the software interrupt vector.
// R19: during break flags clear only with clear enable; cleared stays cleared.
// R20: two-step flag clears stay protected during break; after break clear normally.
// R21: wait and stop clear the mask and stop the cpu clock; exit by interrupt or reset.
// R22: wait stops cpu clocks only; interrupt stacks one cycle later; watchdog stays on.
// R23: reading reset status clears it; power-on sets only the power-on bit.
module sri_sequencer
  import sri_pkg::*;
#(
  parameter int NUM_IRQ = 24
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         addr,
  input  wire logic [7:0]         wdata,
  input  wire logic               wr_stb,
  input  wire logic               rd_stb,
  output logic      [7:0]         rdata,
  input  wire logic               power_on_reset_signal,
  input  wire logic               low_voltage_detect,
  input  wire logic               wdog_timeout,
  input  wire logic               illegal_opcode,
  input  wire logic               illegal_address,
  input  wire logic               rst_vec_fetch,
  input  wire logic [7:0]         rst_vec_byte,
  input  wire logic [NUM_IRQ-1:0] irq_req,
  input  wire logic [NUM_IRQ-1:0] irq_en,
  input  wire logic               i_mask,
  input  wire logic               insn_done,
  input  wire logic               int_ret_done,
  input  wire logic               sw_int_exec,
  input  wire logic               wait_exec,
  input  wire logic               stop_exec,
  input  wire logic               int_ack,
  input  wire logic               break_req,
  output logic                    sys_reset_n,
  output logic                    cpu_clk_en,
  output logic                    periph_clk_en,
  output logic                    monitor_mode,
  output logic                    wdog_tick,
  output logic                    wdog_enable,
  output sri_stack_s              stack_req,
  output logic                    mask_clr,
  output logic                    in_break,
  output logic                    flag_clear_ok
);

  function automatic logic [6:0] sri_pick(input logic [NUM_IRQ-1:0] p);
    logic [6:0] v;
    v = SRI_VEC_SOFT;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (p[i]) begin
        v = 7'(i + 1);
      end
    end
    return v;
  endfunction

  sri_state_e           state_r;
  sri_state_e           state_nxt;
  sri_cfg_s             cfg_r;
  sri_stack_s           stk_r;
  logic [11:0]          cnt_r;
  logic [11:0]          rec_last_r;
  logic [5:0]           sh_r;
  logic [7:0]           rs_r;
  logic [7:0]           rdata_r;
  logic                 clr_en_r;
  logic                 brk_wait_r;
  logic                 lv_meta_r;
  logic                 lv_sync_r;
  logic                 latched_r;
  logic [6:0]           lat_vec_r;
  logic                 i_mask_q_r;
  logic                 wake_r;
  logic                 brk_r;
  logic                 mon_r;
  logic                 mclr_r;
  logic                 vf_arm_r;
  logic                 vf_idx_r;
  logic                 vf_ff_r;
  logic [NUM_IRQ-1:0]   pend;
  logic                 lv_rst_hit;
  logic                 mon_rst_hit;
  logic                 other_rst;
  logic                 rst_evt;
  logic                 in_run;
  logic                 insn_end;
  logic                 i_fall;
  logic                 soft_take;
  logic                 hw_take;
  logic                 brk_wake;
  logic                 rd_rs;

  assign pend     = irq_req & irq_en;
  assign in_run   = (state_r == SQ_RUN);
  // a return is an instruction end, so a still pending source wins the prefetch when i_mask is already clear in the return cycle
  assign insn_end = insn_done | int_ret_done; // [R13]
  assign i_fall   = i_mask_q_r & ~i_mask;
  assign lv_rst_hit  = lv_sync_r & ~cfg_r.lvpd & ~cfg_r.lvrd; // [R2]
  assign mon_rst_hit = vf_arm_r & rst_vec_fetch & vf_idx_r & vf_ff_r
                     & (rst_vec_byte == SRI_ERASED_BYTE); // [R1]
  assign other_rst = wdog_timeout | illegal_opcode | illegal_address | mon_rst_hit;
  assign rst_evt   = power_on_reset_signal | lv_rst_hit | other_rst;
  assign rd_rs     = rd_stb & (addr == SRI_OFS_RST_SRC);
  assign brk_wake  = (state_r == SQ_WAIT) & break_req;

  // resets never enter arbitration; takes only happen in run
  assign soft_take = in_run & ~rst_evt & ~latched_r & ~wake_r
                   & (break_req | (insn_end & sw_int_exec)); // [R15] [R17] [R18]
  assign hw_take  = in_run & ~rst_evt & ~latched_r & ~soft_take & (|pend)
                  & ((insn_end & ~i_mask) | wake_r); // [R11] [R17]

  // low-voltage detector is analog and asynchronous to the core clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lv_meta_r <= 1'b0;
      lv_sync_r <= 1'b0;
    end else begin
      lv_meta_r <= low_voltage_detect;
      lv_sync_r <= lv_meta_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    if (power_on_reset_signal) begin
      state_nxt = SQ_LONG;
    end else if (lv_rst_hit) begin
      state_nxt = SQ_LV_HOLD; // [R2]
    end else if (other_rst) begin
      // reset out of stop still gets the long oscillator settle
      state_nxt = (state_r == SQ_STOP || state_r == SQ_STOP_REC) ? SQ_LONG : SQ_SHORT;
    end else begin
      case (state_r)
        SQ_LV_HOLD:  state_nxt = lv_sync_r ? SQ_LV_HOLD : SQ_LONG; // [R3]
        SQ_LONG:     state_nxt = (cnt_r == SRI_LONG_LAST) ? SQ_SHORT : SQ_LONG; // [R3]
        SQ_SHORT:    state_nxt = (sh_r == SRI_SHORT_LAST) ? SQ_RUN : SQ_SHORT; // [R3]
        SQ_RUN: begin
          if (stop_exec) begin
            state_nxt = SQ_STOP; // [R21]
          end else if (wait_exec) begin
            state_nxt = SQ_WAIT; // [R21]
          end
        end
        SQ_WAIT:     state_nxt = (|pend || break_req) ? SQ_RUN : SQ_WAIT; // [R22]
        SQ_STOP:     state_nxt = (|pend) ? SQ_STOP_REC : SQ_STOP; // [R21]
        SQ_STOP_REC: state_nxt = (cnt_r == rec_last_r) ? SQ_RUN : SQ_STOP_REC;
        default:     state_nxt = SQ_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= SQ_LONG;
    end else begin
      state_r <= state_nxt;
    end
  end

  // system counter: cleared by resets, stop and its hold, otherwise free
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= SRI_CNT_RST;
    end else if (rst_evt || state_r == SQ_LV_HOLD || state_r == SQ_STOP
                 || (in_run && stop_exec)) begin
      cnt_r <= SRI_CNT_RST; // [R6]
    end else begin
      cnt_r <= cnt_r + 12'h001; // [R4] [R8]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sh_r <= 6'h00;
    end else if (state_r == SQ_SHORT && !rst_evt) begin
      sh_r <= sh_r + 6'h01;
    end else begin
      sh_r <= 6'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rec_last_r <= SRI_LONG_LAST;
    end else if (state_r == SQ_STOP && |pend) begin
      rec_last_r <= cfg_r.short_rec ? SRI_SREC_LAST : SRI_LONG_LAST; // [R7]
    end
  end

  // interrupt stacking starts one cycle after a wake from wait or stop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= ~rst_evt & (|pend)
              & ((state_r == SQ_WAIT)
                 | (state_r == SQ_STOP_REC && cnt_r == rec_last_r)); // [R22]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latched_r <= 1'b0;
      lat_vec_r <= SRI_VEC_SOFT;
    end else if (rst_evt || !in_run) begin
      latched_r <= 1'b0; // [R17]
    end else if (soft_take || hw_take) begin
      latched_r <= 1'b1; // [R10]
      lat_vec_r <= soft_take ? SRI_VEC_SOFT : sri_pick(pend); // [R12]
    end else if (int_ack || i_fall) begin
      latched_r <= 1'b0; // [R10]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      i_mask_q_r <= 1'b0;
    end else begin
      i_mask_q_r <= i_mask;
    end
  end

  // take pulse asks the cpu to stack and set the mask
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stk_r <= '0;
    end else begin
      stk_r.take            <= soft_take | hw_take; // [R9]
      stk_r.vec             <= soft_take ? SRI_VEC_SOFT : sri_pick(pend);
      stk_r.pc_minus_one    <= hw_take; // [R16]
      stk_r.push_high_index <= 1'b0; // [R14]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mclr_r <= 1'b0;
    end else begin
      mclr_r <= in_run & ~rst_evt & (wait_exec | stop_exec); // [R21]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      brk_r <= 1'b0;
    end else if (rst_evt) begin
      brk_r <= 1'b0;
    end else if (soft_take && break_req) begin
      brk_r <= 1'b1; // [R18]
    end else if (int_ret_done) begin
      brk_r <= 1'b0;
    end
  end

  // first vector bytes after each release are checked for erased flash
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vf_arm_r <= 1'b0;
      vf_idx_r <= 1'b0;
      vf_ff_r  <= 1'b0;
    end else if (state_r == SQ_SHORT && state_nxt == SQ_RUN) begin
      vf_arm_r <= 1'b1;
      vf_idx_r <= 1'b0;
    end else if (vf_arm_r && rst_vec_fetch) begin
      vf_idx_r <= 1'b1;
      vf_ff_r  <= (rst_vec_byte == SRI_ERASED_BYTE);
      vf_arm_r <= ~vf_idx_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mon_r <= 1'b0;
    end else if (power_on_reset_signal) begin
      mon_r <= 1'b0;
    end else if (mon_rst_hit) begin
      mon_r <= 1'b1; // [R1]
    end
  end

  // reset source bits: a new reset beats a clearing read
  always_ff @(posedge core_clk) begin
    if (!rst_n || power_on_reset_signal) begin
      rs_r <= SRI_RST_SRC_POR; // [R23]
    end else begin
      rs_r <= (rd_rs ? SRI_REG_ZERO : rs_r)
            | {1'b0, 1'b0, wdog_timeout, illegal_opcode, illegal_address,
               mon_rst_hit, lv_rst_hit, 1'b0}; // [R23] [R2]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_r  <= '0;
      clr_en_r <= 1'b0;
    end else if (wr_stb && addr == SRI_OFS_CFG) begin
      cfg_r <= sri_cfg_s'(wdata[SRI_CFG_WDD:SRI_CFG_LVPD]);
    end else if (wr_stb && addr == SRI_OFS_BRK_CTL) begin
      clr_en_r <= wdata[SRI_BC_CLR_EN];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      brk_wait_r <= 1'b0;
    end else if (brk_wake) begin
      brk_wait_r <= 1'b1;
    end else if (wr_stb && addr == SRI_OFS_BRK_STAT && !wdata[SRI_BS_WAIT_EXIT]) begin
      brk_wait_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= SRI_REG_ZERO;
    end else begin
      rdata_r <= SRI_REG_ZERO;
      if (rd_stb) begin
        case (addr)
          SRI_OFS_BRK_STAT: rdata_r[SRI_BS_WAIT_EXIT] <= brk_wait_r;
          SRI_OFS_RST_SRC:  rdata_r <= rs_r;
          SRI_OFS_BRK_CTL:  rdata_r[SRI_BC_CLR_EN] <= clr_en_r;
          SRI_OFS_CFG:      rdata_r[SRI_CFG_WDD:SRI_CFG_LVPD] <= cfg_r;
          default:          rdata_r <= SRI_REG_ZERO;
        endcase
      end
    end
  end

  assign rdata         = rdata_r;
  assign sys_reset_n   = ~(state_r == SQ_LV_HOLD || state_r == SQ_LONG
                           || state_r == SQ_SHORT); // [R3]
  assign cpu_clk_en    = in_run; // [R21]
  assign periph_clk_en = ~(state_r == SQ_STOP || state_r == SQ_STOP_REC) & sys_reset_n; // [R22]
  assign monitor_mode  = mon_r;
  assign wdog_tick     = (cnt_r == SRI_CNT_MAX) & sys_reset_n; // [R5]
  assign wdog_enable   = ~cfg_r.wdd; // [R22]
  assign stack_req     = stk_r;
  assign mask_clr      = mclr_r;
  assign in_break      = brk_r;
  // peripherals gate both clearing steps on this, so early first steps stay harmless
  assign flag_clear_ok = ~brk_r | clr_en_r; // [R19] [R20]

  property p_mon_entry;
    @(posedge core_clk) disable iff (!rst_n)
    mon_rst_hit && !power_on_reset_signal && !lv_rst_hit
      |=> !sys_reset_n && rs_r[SRI_RS_MONENT] ##[1:80] monitor_mode && sys_reset_n;
  endproperty
  a_mon_entry: assert property (p_mon_entry) else $error("erased vector did not reset"); // [R1]

  property p_lowv;
    @(posedge core_clk) disable iff (!rst_n)
    lv_rst_hit && !power_on_reset_signal |=> state_r == SQ_LV_HOLD && rs_r[SRI_RS_LOWV];
  endproperty
  a_lowv: assert property (p_lowv) else $error("low voltage reset missed"); // [R2]

  property p_long_end;
    @(posedge core_clk) disable iff (!rst_n)
    state_r == SQ_LONG && cnt_r == SRI_LONG_LAST && !rst_evt
      |=> state_r == SQ_SHORT ##63 state_r == SQ_SHORT ##1 (state_r == SQ_RUN || rst_evt);
  endproperty
  a_long_end: assert property (p_long_end) else $error("reset phase length wrong"); // [R3]

  property p_free_run;
    @(posedge core_clk) disable iff (!rst_n)
    in_run && !rst_evt && !stop_exec |=> cnt_r == $past(cnt_r) + 12'h001;
  endproperty
  a_free_run: assert property (p_free_run) else $error("counter not free running"); // [R8]

  property p_stop_clr;
    @(posedge core_clk) disable iff (!rst_n)
    in_run && stop_exec && !rst_evt |=> cnt_r == SRI_CNT_RST && state_r == SQ_STOP;
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stop did not clear counter"); // [R6]

  // a reset event during recovery restarts sequencing, so it drops the attempt
  property p_short_rec;
    @(posedge core_clk) disable iff (!rst_n || rst_evt)
    state_r == SQ_STOP && |pend && cfg_r.short_rec
      |=> ##31 state_r == SQ_STOP_REC ##1 state_r == SQ_RUN;
  endproperty
  a_short_rec: assert property (p_short_rec) else $error("short stop recovery length"); // [R7]

  property p_soft;
    @(posedge core_clk) disable iff (!rst_n)
    soft_take |=> stack_req.take && stack_req.vec == SRI_VEC_SOFT && !stack_req.pc_minus_one;
  endproperty
  a_soft: assert property (p_soft) else $error("software interrupt not forced"); // [R15]

  property p_hw_mask;
    @(posedge core_clk) disable iff (!rst_n)
    stack_req.take && stack_req.pc_minus_one |-> !$past(i_mask) || $past(wake_r);
  endproperty
  a_hw_mask: assert property (p_hw_mask) else $error("masked interrupt taken"); // [R11]

  property p_hold_latch;
    @(posedge core_clk) disable iff (!rst_n)
    latched_r && in_run && !rst_evt && !int_ack && !i_fall |=> latched_r && $stable(lat_vec_r);
  endproperty
  a_hold_latch: assert property (p_hold_latch) else $error("latched vector overridden"); // [R10]

  property p_rst_first;
    @(posedge core_clk) disable iff (!rst_n)
    !sys_reset_n |=> !stack_req.take;
  endproperty
  a_rst_first: assert property (p_rst_first) else $error("interrupt taken in reset"); // [R17]

  property p_rs_read;
    @(posedge core_clk) disable iff (!rst_n)
    rd_rs && !rst_evt |=> rdata == $past(rs_r) && rs_r == SRI_REG_ZERO;
  endproperty
  a_rs_read: assert property (p_rs_read) else $error("status read did not clear"); // [R23]

endmodule // sri_sequencer

// >>> dv/sri_cpu_model.sv
`timescale 1ns/1ps
// cpu side of the vector handshake: acknowledges a take and owns the mask bit
module sri_cpu_model
  import sri_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire sri_stack_s stack_req,
  input  wire logic       mask_clr,
  input  wire logic       int_ret_done,
  input  wire logic       slow,
  output logic            i_mask,
  output logic            int_ack
);
  int ack_cnt;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_cnt <= 0;
      i_mask  <= 1'b1;
      int_ack <= 1'b0;
    end else begin
      // slow mode stretches the vector fetch to expose latch hold
      if (stack_req.take) ack_cnt <= slow ? 5 : 1;
      else if (ack_cnt != 0) ack_cnt <= ack_cnt - 1;
      int_ack <= (ack_cnt == 1);
      if (ack_cnt == 1) i_mask <= 1'b1;
      if (int_ret_done || mask_clr) i_mask <= 1'b0;
    end
  end
endmodule // sri_cpu_model

// >>> dv/tb_sri_sequencer.sv
`timescale 1ns/1ps
module tb_sri_sequencer;
  import sri_pkg::*;
  localparam int         NIRQ = 24;
  localparam logic [6:0] INS  = 7'h01;
  localparam logic [6:0] SOFT = 7'h02;
  localparam logic [6:0] WT   = 7'h04;
  localparam logic [6:0] STP  = 7'h08;
  localparam logic [6:0] RET  = 7'h10;
  localparam logic [6:0] BRK  = 7'h20;
  localparam logic [6:0] WDT  = 7'h40;
  logic             core_clk, rst_n, wr_stb, rd_stb, slow, got, i_mask, int_ack;
  logic             power_on_reset_signal, low_voltage_detect, illegal_opcode;
  logic             illegal_address, rst_vec_fetch, sys_reset_n, cpu_clk_en;
  logic             periph_clk_en, monitor_mode, wdog_tick, wdog_enable, mask_clr;
  logic             in_break, flag_clear_ok;
  logic [6:0]       pv;
  logic [7:0]       addr, wdata, rdata, rst_vec_byte, rv;
  logic [NIRQ-1:0]  irq_req, irq_en;
  sri_stack_s       stack_req;
  wire              insn_done, sw_int_exec, wait_exec, stop_exec, int_ret_done, break_req;
  wire              wdog_timeout;
  int               n_fail = 0, tests_run = 0, cyc = 0, n, e;

  assign {wdog_timeout, break_req, int_ret_done, stop_exec, wait_exec, sw_int_exec,
          insn_done} = pv;

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  sri_sequencer sri_sequencer_inst (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .power_on_reset_signal(power_on_reset_signal),
    .low_voltage_detect(low_voltage_detect), .wdog_timeout(wdog_timeout),
    .illegal_opcode(illegal_opcode), .illegal_address(illegal_address),
    .rst_vec_fetch(rst_vec_fetch), .rst_vec_byte(rst_vec_byte), .irq_req(irq_req),
    .irq_en(irq_en), .i_mask(i_mask), .insn_done(insn_done), .int_ret_done(int_ret_done),
    .sw_int_exec(sw_int_exec), .wait_exec(wait_exec), .stop_exec(stop_exec), .int_ack(int_ack),
    .break_req(break_req), .sys_reset_n(sys_reset_n), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .monitor_mode(monitor_mode), .wdog_tick(wdog_tick),
    .wdog_enable(wdog_enable), .stack_req(stack_req), .mask_clr(mask_clr),
    .in_break(in_break), .flag_clear_ok(flag_clear_ok)
  );

  sri_cpu_model sri_cpu_model_inst (
    .core_clk(core_clk), .rst_n(rst_n), .stack_req(stack_req), .mask_clr(mask_clr),
    .int_ret_done(int_ret_done), .slow(slow), .i_mask(i_mask), .int_ack(int_ack)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k = 1);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic pulse(input logic [6:0] m);
    @(posedge core_clk);
    pv <= m;
    @(posedge core_clk);
    pv <= 7'h00;
    #1;
  endtask

  task automatic wait_take(input int lim);
    n = 0;
    while (stack_req.take !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    got = (stack_req.take === 1'b1);
  endtask

  task automatic wait_run(input int lim);
    n = 0;
    while (sys_reset_n !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
  endtask

  task automatic set_irq(input logic [NIRQ-1:0] r, input logic [NIRQ-1:0] en);
    @(posedge core_clk);
    irq_req <= r;
    irq_en <= en;
    #1;
  endtask

  // reference arbitration: lowest index wins, vector is index plus one
  function automatic int exp_vec(input logic [NIRQ-1:0] p);
    for (int i = 0; i < NIRQ; i++) if (p[i]) return i + 1;
    return 0;
  endfunction

  initial begin
    void'($urandom(24));
    rst_n = 1'b0; addr = 8'h00; wdata = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
    pv = 7'h00; slow = 1'b0; power_on_reset_signal = 1'b0; low_voltage_detect = 1'b0;
    illegal_opcode = 1'b0; illegal_address = 1'b0; rst_vec_fetch = 1'b0;
    rst_vec_byte = 8'h00; irq_req = '0; irq_en = '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    tick();
    wait_run(5000);
    chk("por_len", n >= 4158 && n <= 4162, 1);
    rd(SRI_OFS_RST_SRC);
    chk("por_stat", rv, 8'h80);
    rd(SRI_OFS_RST_SRC);
    chk("stat_clr", rv, 8'h00);
    pulse(RET);
    for (int k = 0; k < 20; k++) begin
      slow <= k[0];
      set_irq(NIRQ'($urandom) & NIRQ'($urandom), NIRQ'($urandom));
      pulse(INS);
      e = exp_vec(irq_req & irq_en);
      wait_take(3);
      chk("take", got, e != 0);
      if (got) begin
        chk("vec", stack_req.vec, e);
        chk("pcm1", stack_req.pc_minus_one, 1);
        chk("hix", stack_req.push_high_index, 0);
        tick(8);
        pulse(INS);
        wait_take(3);
        chk("masked", got, 0);
        pulse(RET);
      end
      set_irq('0, '0);
    end
    set_irq(24'h00_0004, 24'h00_0004);
    pulse(INS);
    tick(8);
    set_irq('0, '0);
    pulse(INS | SOFT);
    wait_take(3);
    chk("soft_vec", {got, stack_req.vec, stack_req.pc_minus_one}, 9'h100);
    tick(8);
    pulse(RET);
    pulse(BRK);
    wait_take(3);
    chk("brk_vec", {got, stack_req.vec}, 8'h80);
    chk("brk_prot", {in_break, flag_clear_ok}, 2'b10);
    wr(SRI_OFS_BRK_CTL, 8'h80);
    tick();
    chk("brk_clr_en", flag_clear_ok, 1);
    wr(SRI_OFS_BRK_CTL, 8'h00);
    tick(8);
    pulse(RET);
    chk("brk_end", {in_break, flag_clear_ok}, 2'b01);
    pulse(WT);
    chk("wait_ent", {mask_clr, cpu_clk_en, periph_clk_en}, 3'b101);
    set_irq(24'h00_0001, 24'h00_0001);
    wait_take(4);
    chk("wait_wake", {got, stack_req.vec}, 8'h81);
    tick(8);
    set_irq('0, '0);
    pulse(RET);
    // short then long recovery, both timed from the irq edge
    for (int s = 1; s >= 0; s--) begin
      wr(SRI_OFS_CFG, s ? 8'h04 : 8'h00);
      pulse(STP);
      chk("stop_clk", {cpu_clk_en, periph_clk_en}, 2'b00);
      set_irq(24'h00_0001, 24'h00_0001);
      wait_take(5000);
      e = s ? 32 : 4096;
      chk("stop_rec", n >= e && n <= e + 4, 1);
      tick(8);
      set_irq('0, '0);
      pulse(RET);
    end
    wr(SRI_OFS_CFG, 8'h08);
    tick();
    chk("wdog_off", wdog_enable, 0);
    wr(SRI_OFS_CFG, 8'h00);
    tick();
    chk("wdog_on", wdog_enable, 1);
    n = 0;
    while (wdog_tick !== 1'b1 && n < 4200) begin
      tick();
      n++;
    end
    tick();
    n = 1;
    while (wdog_tick !== 1'b1 && n < 4200) begin
      tick();
      n++;
    end
    chk("wdog_period", n, 4096);
    set_irq(24'h00_0001, 24'h00_0001);
    pulse(INS | WDT);
    wait_take(3);
    chk("rst_prio", {got, sys_reset_n}, 2'b00);
    set_irq('0, '0);
    wait_run(200);
    repeat (2) begin
      @(posedge core_clk);
      rst_vec_fetch <= 1'b1;
      rst_vec_byte <= 8'hFF;
    end
    @(posedge core_clk);
    rst_vec_fetch <= 1'b0;
    tick(3);
    chk("erased_rst", sys_reset_n, 0);
    wait_run(200);
    chk("monitor", monitor_mode, 1);
    rd(SRI_OFS_RST_SRC);
    chk("wdt_mon_stat", rv & 8'h24, 8'h24);
    wr(SRI_OFS_CFG, 8'h02);
    low_voltage_detect <= 1'b1;
    tick(20);
    chk("lv_disabled", sys_reset_n, 1);
    low_voltage_detect <= 1'b0;
    wr(SRI_OFS_CFG, 8'h00);
    low_voltage_detect <= 1'b1;
    tick(20);
    chk("lv_rst", sys_reset_n, 0);
    low_voltage_detect <= 1'b0;
    wait_run(5000);
    chk("lv_len", n >= 4160 && n <= 4170, 1);
    rd(SRI_OFS_RST_SRC);
    chk("lv_stat", rv & 8'h02, 8'h02);
    // both illegal-fetch causes in one cycle: one short reset, both bits kept
    @(posedge core_clk);
    illegal_opcode <= 1'b1;
    illegal_address <= 1'b1;
    @(posedge core_clk);
    illegal_opcode <= 1'b0;
    illegal_address <= 1'b0;
    tick(2);
    chk("ill_rst", sys_reset_n, 0);
    wait_run(200);
    rd(SRI_OFS_RST_SRC);
    chk("ill_stat", rv, 8'h18);
    report_and_stop();
  end
endmodule // tb_sri_sequencer
